/* File: src/eia_defs.svh */
// Register indices, field codes and timing constants of the error arbiter
`ifndef EIA_DEFS_SVH
`define EIA_DEFS_SVH
// ==========================================
// Register indices (byte address = index * 4)
`define EIA_IDX_MODE 12'h610
`define EIA_IDX_ROUTE 12'h611
`define EIA_IDX_SYS_FMT 12'h612
`define EIA_IDX_CLK_FMT 12'h613
`define EIA_IDX_SYS_PW 12'h616
`define EIA_IDX_CLK_PW 12'h617
`define EIA_IDX_ISV_HI 12'h619
`define EIA_IDX_ISV_LO 12'h6FC
// ==========================================
// Field codes and reset values
`define EIA_MODE_OFF 8'h00
`define EIA_MODE_FLAT 8'h01
`define EIA_MODE_TIER 8'h02
`define EIA_MODE_PRE 8'h12
`define EIA_ROUTE_ON 8'h01
`define EIA_FMT_LOW_BIT 0
`define EIA_FMT_PULSE_BIT 4
`define EIA_RST_BYTE 8'h00
`define EIA_ISV_NONE 8'h00
// In-service code prefixes per source group
`define EIA_CODE_FG 5'h02
`define EIA_CODE_GP 5'h04
`define EIA_CODE_SYS 4'h4
`define EIA_CODE_CLK 4'h8
// Source index boundaries: FG, GP, SYS, CLK
`define EIA_BASE_GP 6'd8
`define EIA_BASE_SYS 6'd16
`define EIA_BASE_CLK 6'd32
`define EIA_SRC_N 7'd48
// ==========================================
// Pulse time base: 32.768 MHz from 250 MHz, in kHz
`define EIA_TICK_KHZ 18'd32768
`define EIA_CLK_KHZ 18'd250000
`endif

/* File: src/eia_pkg.sv */
// Types shared by the error interrupt arbiter
`default_nettype none
package eia_pkg;
   // ==========================================
   // Pending sources, index 0 = frame group bit 0
   typedef struct packed {
      logic [15:0] clock_error_sources;
      logic [15:0] system_error_sources;
      logic [7:0] general_purpose_inputs;
      logic [7:0] frame_group_inputs;
   } eia_src_type;
   // Service sequencer
   typedef enum logic {ST_IDLE, ST_SERVE} eia_state_type;
   // Priority tier of a source
   typedef enum logic [1:0] {TIER_EXT, TIER_SYS, TIER_CLK} eia_tier_type;
endpackage
`default_nettype wire

/* File: src/eia_error_arbiter.sv */
// Error interrupt arbiter: mode control, arbitration, output formatting
//
// Implementation choice: register access over APB.
`default_nettype none
`include "eia_defs.svh"
module eia_error_arbiter
   import eia_pkg::*;
#(
   parameter int PW_W = 8
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [13:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Pending bits from the source registers
   input wire eia_src_type PEND_SRC,
   output logic [47:0] PEND_CLR,
   // Error outputs
   output logic SYSTEM_ERROR_OUTPUT,
   output logic CLOCK_ERROR_OUTPUT,
   output logic PCI_INTERRUPT_LINE_O,
   output logic PCI_INTERRUPT_LINE_OE
);
   // ==========================================
   // Helper functions
   // Byte address of a register index
   function automatic logic [13:0] baddr(input logic [11:0] idx);
      baddr = {idx, 2'b00};
   endfunction

   // Tier of a source index
   function automatic eia_tier_type tier_of(input logic [5:0] i);
      if (i >= `EIA_BASE_CLK) begin
         tier_of = TIER_CLK;
      end else if (i >= `EIA_BASE_SYS) begin
         tier_of = TIER_SYS;
      end else begin
         tier_of = TIER_EXT;
      end
   endfunction

   // In-service code of a source index
   function automatic logic [7:0] code_of(input logic [5:0] i);
      case (tier_of(i))
         TIER_CLK: code_of = {`EIA_CODE_CLK, i[3:0]};
         TIER_SYS: code_of = {`EIA_CODE_SYS, i[3:0]};
         default: begin
            if (i >= `EIA_BASE_GP) begin
               code_of = {`EIA_CODE_GP, i[2:0]};
            end else begin
               code_of = {`EIA_CODE_FG, i[2:0]};
            end
         end
      endcase
   endfunction

   // Round-robin pick: first set bit after the pointer
   function automatic logic [5:0] rr_pick(input logic [47:0] v, input logic [5:0] p);
      logic [6:0] k;
      rr_pick = p;
      // Scan far to near so the nearest set bit wins
      for (int i = 47; i >= 0; i--) begin
         k = 7'(p) + 7'(i) + 7'd1;
         if (k >= `EIA_SRC_N) begin
            k = k - `EIA_SRC_N;
         end
         if (v[k[5:0]]) begin
            rr_pick = k[5:0];
         end
      end
   endfunction

   // ==========================================
   // Register file
   logic [7:0] arbitration_mode_field_r; // Mode select
   logic [7:0] pci_route_field_r; // PCI routing
   logic [7:0] sys_out_format_field_r; // System output format
   logic [7:0] clk_out_format_field_r; // Clock output format
   logic [PW_W-1:0] sys_pulse_width_field_r; // System pulse width
   logic [PW_W-1:0] clk_pulse_width_field_r; // Clock pulse width
   logic [7:0] in_service_code_field_r; // Serviced source code
   logic [31:0] prdata_r; // Read data
   logic wr_en; // Write takes effect
   logic rd_setup; // Read setup phase
   logic hit; // Address is mapped
   logic ack; // Software ends service

   // Decode
   always_comb begin
      hit = (PADDR == baddr(`EIA_IDX_MODE)) || (PADDR == baddr(`EIA_IDX_ROUTE)) ||
            (PADDR == baddr(`EIA_IDX_SYS_FMT)) || (PADDR == baddr(`EIA_IDX_CLK_FMT)) ||
            (PADDR == baddr(`EIA_IDX_SYS_PW)) || (PADDR == baddr(`EIA_IDX_CLK_PW)) ||
            (PADDR == baddr(`EIA_IDX_ISV_HI)) || (PADDR == baddr(`EIA_IDX_ISV_LO));
   end

   // Zero wait states; unmapped access flags an error
   assign wr_en = PSEL && PENABLE && PWRITE && hit;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;
   assign ack = wr_en && (PADDR == baddr(`EIA_IDX_ISV_HI));
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;
   assign PRDATA = prdata_r;

   // Writable registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         arbitration_mode_field_r <= `EIA_MODE_OFF;
         pci_route_field_r <= `EIA_RST_BYTE;
         sys_out_format_field_r <= `EIA_RST_BYTE;
         clk_out_format_field_r <= `EIA_RST_BYTE;
         sys_pulse_width_field_r <= '0;
         clk_pulse_width_field_r <= '0;
      end else if (wr_en) begin
         case (PADDR)
            baddr(`EIA_IDX_MODE): arbitration_mode_field_r <= PWDATA[7:0];
            baddr(`EIA_IDX_ROUTE): pci_route_field_r <= PWDATA[7:0];
            baddr(`EIA_IDX_SYS_FMT): sys_out_format_field_r <= PWDATA[7:0];
            baddr(`EIA_IDX_CLK_FMT): clk_out_format_field_r <= PWDATA[7:0];
            baddr(`EIA_IDX_SYS_PW): sys_pulse_width_field_r <= PWDATA[PW_W-1:0];
            baddr(`EIA_IDX_CLK_PW): clk_pulse_width_field_r <= PWDATA[PW_W-1:0];
            default: ;
         endcase
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prdata_r <= '0;
      end else if (rd_setup) begin
         case (PADDR)
            baddr(`EIA_IDX_MODE): prdata_r <= {24'h000000, arbitration_mode_field_r};
            baddr(`EIA_IDX_ROUTE): prdata_r <= {24'h000000, pci_route_field_r};
            baddr(`EIA_IDX_SYS_FMT): prdata_r <= {24'h000000, sys_out_format_field_r};
            baddr(`EIA_IDX_CLK_FMT): prdata_r <= {24'h000000, clk_out_format_field_r};
            baddr(`EIA_IDX_SYS_PW): prdata_r <= 32'(sys_pulse_width_field_r);
            baddr(`EIA_IDX_CLK_PW): prdata_r <= 32'(clk_pulse_width_field_r);
            baddr(`EIA_IDX_ISV_HI): prdata_r <= {24'h000000, in_service_code_field_r};
            default: prdata_r <= '0; // Low byte and unmapped read zero
         endcase
      end
   end

   // ==========================================
   // Arbitration
   logic arb_on; // Controller active
   logic tiered; // Tier or pre-empt mode
   logic [47:0] pend_v; // All pending bits
   logic [47:0] arb_v; // Candidates this cycle
   eia_tier_type top_tier; // Highest non-empty tier
   logic [5:0] win; // Round-robin winner
   logic can_load; // Winner enters service
   eia_state_type state_r; // Service state
   eia_tier_type cur_tier_r; // Tier in service
   logic [5:0] ptr_r; // Last winner
   logic load_r; // Service started last edge
   logic [47:0] clr_r; // Pending clear pulse

   // Unlisted codes behave as disabled
   assign arb_on = (arbitration_mode_field_r == `EIA_MODE_FLAT) ||
                   (arbitration_mode_field_r == `EIA_MODE_TIER) ||
                   (arbitration_mode_field_r == `EIA_MODE_PRE);
   assign tiered = (arbitration_mode_field_r == `EIA_MODE_TIER) ||
                   (arbitration_mode_field_r == `EIA_MODE_PRE);
   assign pend_v = PEND_SRC;

   // Candidate selection per mode
   always_comb begin
      if (|PEND_SRC.clock_error_sources) begin
         top_tier = TIER_CLK;
      end else if (|PEND_SRC.system_error_sources) begin
         top_tier = TIER_SYS;
      end else begin
         top_tier = TIER_EXT;
      end
      arb_v = pend_v;
      if (tiered) begin
         // Only the top tier competes
         for (int i = 0; i < 48; i++) begin
            arb_v[i] = pend_v[i] && (tier_of(6'(i)) == top_tier);
         end
      end
      win = rr_pick(arb_v, ptr_r);
      can_load = arb_on && (|arb_v) && ((state_r == ST_IDLE) ||
                 ((arbitration_mode_field_r == `EIA_MODE_PRE) && (top_tier > cur_tier_r)));
   end

   // Service sequencer; acknowledge wins over a same-cycle pre-empt
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= ST_IDLE;
         cur_tier_r <= TIER_EXT;
         ptr_r <= 6'(`EIA_SRC_N - 7'd1);
         in_service_code_field_r <= `EIA_ISV_NONE;
         load_r <= 1'b0;
      end else begin
         load_r <= 1'b0;
         if (!arb_on) begin
            // Bypass: nothing is queued
            state_r <= ST_IDLE;
            in_service_code_field_r <= `EIA_ISV_NONE;
         end else if (ack && (state_r == ST_SERVE)) begin
            state_r <= ST_IDLE;
            in_service_code_field_r <= `EIA_ISV_NONE;
         end else if (can_load) begin
            state_r <= ST_SERVE;
            cur_tier_r <= tier_of(win);
            ptr_r <= win;
            in_service_code_field_r <= code_of(win);
            load_r <= 1'b1;
         end
      end
   end

   // One-cycle clear of the winner's pending bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         clr_r <= '0;
      end else begin
         for (int i = 0; i < 48; i++) begin
            clr_r[i] <= can_load && !(ack && (state_r == ST_SERVE)) && (win == 6'(i));
         end
      end
   end
   assign PEND_CLR = clr_r;

   // ==========================================
   // Pulse time base: fractional divider, jitter of one CLK
   logic [17:0] acc_r; // Phase accumulator
   logic tick_r; // One 32.768 MHz period elapsed
   logic [18:0] acc_sum; // One bit wider, the sum can pass 2**18

   assign acc_sum = 19'(acc_r) + 19'(`EIA_TICK_KHZ);

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         acc_r <= '0;
         tick_r <= 1'b0;
      end else if (acc_sum >= 19'(`EIA_CLK_KHZ)) begin
         acc_r <= 18'(acc_sum - 19'(`EIA_CLK_KHZ));
         tick_r <= 1'b1;
      end else begin
         acc_r <= 18'(acc_sum);
         tick_r <= 1'b0;
      end
   end

   // ==========================================
   // Output formatting: channel 0 system, channel 1 clock
   logic [1:0] trig; // Raw trigger levels
   logic [1:0] evt; // Trigger events
   logic [1:0] act; // Output active (before polarity)
   logic [1:0] out_r; // Pin values
   logic [7:0] fmt [2]; // Format selects
   logic [PW_W-1:0] pw [2]; // Pulse widths

   // Disabled: OR of pending bits holds the level
   assign trig[0] = arb_on ? (state_r == ST_SERVE) : |PEND_SRC.system_error_sources;
   assign trig[1] = arb_on ? ((state_r == ST_SERVE) && (cur_tier_r == TIER_CLK)) :
                    |PEND_SRC.clock_error_sources;
   assign fmt[0] = sys_out_format_field_r;
   assign fmt[1] = clk_out_format_field_r;
   assign pw[0] = sys_pulse_width_field_r;
   assign pw[1] = clk_pulse_width_field_r;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_chan
         logic trig_d_r; // Trigger delayed
         logic armed_r; // Pulse waits for tick
         logic busy_r; // Pulse in progress
         logic again_r; // Event seen during pulse
         logic [PW_W-1:0] cnt_r; // Ticks elapsed
         logic pulse_mode; // Pulse format chosen

         assign pulse_mode = fmt[g][`EIA_FMT_PULSE_BIT];
         // Each load that leaves the trigger set is an event in arbitrated modes
         assign evt[g] = arb_on ? (load_r && trig[g]) : (trig[g] && !trig_d_r);
         assign act[g] = pulse_mode ? busy_r : trig[g];

         // Pulse starts on a tick so it spans whole periods
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               trig_d_r <= 1'b0;
               armed_r <= 1'b0;
               busy_r <= 1'b0;
               again_r <= 1'b0;
               cnt_r <= '0;
            end else begin
               trig_d_r <= trig[g];
               if (!pulse_mode) begin
                  armed_r <= 1'b0;
                  busy_r <= 1'b0;
                  again_r <= 1'b0;
               end else begin
                  // Events during a pulse are merged into one queued repeat
                  if (evt[g] && (armed_r || busy_r)) begin
                     again_r <= 1'b1;
                  end else if (evt[g]) begin
                     armed_r <= 1'b1;
                  end
                  if (tick_r && armed_r && !busy_r) begin
                     armed_r <= evt[g];
                     busy_r <= 1'b1;
                     cnt_r <= '0;
                  end else if (tick_r && busy_r) begin
                     if (cnt_r == pw[g]) begin
                        busy_r <= 1'b0; // width+1 ticks done
                        if (again_r && !evt[g]) begin
                           armed_r <= 1'b1;
                           again_r <= 1'b0;
                        end
                     end else begin
                        cnt_r <= cnt_r + 1'b1;
                     end
                  end
               end
            end
         end

         // Polarity applied last
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               out_r[g] <= 1'b0;
            end else begin
               out_r[g] <= act[g] ^ fmt[g][`EIA_FMT_LOW_BIT];
            end
         end
      end
   endgenerate

   assign SYSTEM_ERROR_OUTPUT = out_r[0];
   assign CLOCK_ERROR_OUTPUT = out_r[1];

   // ==========================================
   // PCI line: open drain, pulled low while active
   logic pci_oe_r; // Drive enable

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pci_oe_r <= 1'b0;
      end else begin
         pci_oe_r <= (pci_route_field_r == `EIA_ROUTE_ON) && act[0];
      end
   end
   assign PCI_INTERRUPT_LINE_O = 1'b0;
   assign PCI_INTERRUPT_LINE_OE = pci_oe_r;

   // ==========================================
   // Assertions
   sequence s_load;
      can_load && !(ack && (state_r == ST_SERVE));
   endsequence
   sequence s_served;
      ##1 (state_r == ST_SERVE) && load_r;
   endsequence

   property p_bypass;
      @(posedge CLK) disable iff (!RESET_N)
      (!arb_on && (sys_out_format_field_r == `EIA_RST_BYTE)) ##1 (sys_out_format_field_r == `EIA_RST_BYTE)
      |-> SYSTEM_ERROR_OUTPUT == $past(|PEND_SRC.system_error_sources);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass output is not the OR");

   property p_no_clear_off;
      @(posedge CLK) disable iff (!RESET_N)
      !arb_on |=> PEND_CLR == '0;
   endproperty
   a_no_clear_off: assert property (p_no_clear_off) else $error("clear issued while disabled");

   property p_load;
      @(posedge CLK) disable iff (!RESET_N)
      s_load |-> s_served ##0 (in_service_code_field_r == code_of($past(win))) ##0 PEND_CLR[$past(win)];
   endproperty
   a_load: assert property (p_load) else $error("winner not loaded and cleared");

   property p_tier;
      @(posedge CLK) disable iff (!RESET_N)
      (s_load and (tiered && (|PEND_SRC.clock_error_sources))) |=> in_service_code_field_r[7:4] == `EIA_CODE_CLK;
   endproperty
   a_tier: assert property (p_tier) else $error("clock tier not served first");

   property p_no_preempt;
      @(posedge CLK) disable iff (!RESET_N)
      ((arbitration_mode_field_r != `EIA_MODE_PRE) && (state_r == ST_SERVE)) |=> !load_r;
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("service replaced without pre-empt");

   property p_pci;
      @(posedge CLK) disable iff (!RESET_N)
      (pci_route_field_r != `EIA_ROUTE_ON) |=> !PCI_INTERRUPT_LINE_OE;
   endproperty
   a_pci: assert property (p_pci) else $error("PCI line driven while not routed");

   property p_isv_low;
      @(posedge CLK) disable iff (!RESET_N)
      (rd_setup && (PADDR == baddr(`EIA_IDX_ISV_LO))) |=> PRDATA == '0;
   endproperty
   a_isv_low: assert property (p_isv_low) else $error("in-service low byte not zero");

   property p_isv_valid;
      @(posedge CLK) disable iff (!RESET_N)
      (state_r == ST_SERVE) |-> in_service_code_field_r != `EIA_ISV_NONE;
   endproperty
   a_isv_valid: assert property (p_isv_valid) else $error("service without a vector");

   property p_pulse_start;
      @(posedge CLK) disable iff (!RESET_N)
      $rose(g_chan[0].busy_r) |-> $past(g_chan[0].armed_r) && $past(tick_r);
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse began without event");
endmodule
`default_nettype wire

/* File: verif/eia_pend_model.sv */
// Pending-source model that feeds the arbiter and obeys its clears
`default_nettype none
module eia_pend_model
   import eia_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Source events and clears
   input wire logic [47:0] set_bits,
   input wire logic [47:0] sw_clr,
   input wire logic [47:0] hw_clr,
   // Pending state
   output eia_src_type pend
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [47:0] pend_r; // Latched events
   // ==========================================
   // Pending latch: a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_r <= 48'h0;
      end else begin
         pend_r <= (pend_r & ~(sw_clr | hw_clr)) | set_bits;
      end
   end
   assign pend = eia_src_type'(pend_r);
endmodule
`default_nettype wire

/* File: verif/tb_eia_error_arbiter.sv */
// Self-checking bench of the error interrupt arbiter
`default_nettype none
`include "eia_defs.svh"
module tb_eia_error_arbiter
   import eia_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset_n = 1'b0; // Clock and reset
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB master
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   eia_src_type pend; // Model pending bits
   logic [47:0] pend_clr, set_r = 48'h0, sw_clr_r = 48'h0;
   logic sys_o, clk_o, pci_o, pci_oe; // Error outputs
   int mismatches = 0, tests_run = 0;
   always #2 clk = ~clk;
   eia_error_arbiter eia_error_arbiter_i (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PEND_SRC(pend), .PEND_CLR(pend_clr), .SYSTEM_ERROR_OUTPUT(sys_o), .CLOCK_ERROR_OUTPUT(clk_o),
      .PCI_INTERRUPT_LINE_O(pci_o), .PCI_INTERRUPT_LINE_OE(pci_oe));
   eia_pend_model eia_pend_model_i (.clk(clk), .reset_n(reset_n), .set_bits(set_r), .sw_clr(sw_clr_r),
      .hw_clr(pend_clr), .pend(pend));
   // ==========================================
   // Shared tasks
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; waits for pready, then releases and idles a cycle
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, idx, d, rd, e);
   endtask
   task automatic rdchk(input string what, input logic [11:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic e;
      apb(1'b0, idx, 8'h00, rd, e);
      check(what, rd, exp);
   endtask
   // One-cycle source events, then settle
   task automatic raise(input logic [47:0] m);
      set_r <= m;
      @(posedge clk);
      set_r <= 48'h0;
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [7:0] code_of(input int k);
      if (k < 8) return 8'h10 | 8'(k);
      if (k < 16) return 8'h20 | 8'(k - 8);
      if (k < 32) return 8'h40 | 8'(k - 16);
      return 8'h80 | 8'(k - 32);
   endfunction
   // Check the code in service, then end the service
   task automatic nxt(input int k);
      rdchk("code", `EIA_IDX_ISV_HI, {24'h0, code_of(k)});
      check("pending cleared", 32'(pend[k]), 32'h0);
      wr(`EIA_IDX_ISV_HI, 8'h00);
      repeat (3) @(posedge clk);
   endtask
   // Count cycles at the given level on both outputs
   task automatic measure(input logic lv, output int hs, output int hc);
      hs = 0;
      hc = 0;
      repeat (60) begin
         @(posedge clk);
         if (sys_o === lv) hs++;
         if (clk_o === lv) hc++;
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      rdchk("mode", `EIA_IDX_MODE, 32'h0);
      rdchk("route", `EIA_IDX_ROUTE, 32'h0);
      rdchk("sys fmt", `EIA_IDX_SYS_FMT, 32'h0);
      rdchk("clk fmt", `EIA_IDX_CLK_FMT, 32'h0);
      rdchk("isv hi", `EIA_IDX_ISV_HI, 32'h0);
      rdchk("isv lo", `EIA_IDX_ISV_LO, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_off();
      logic [31:0] rd;
      logic e;
      apb(1'b0, 12'h600, 8'h00, rd, e);
      check("unmapped err", 32'(e), 32'h1);
      raise(48'h1 << 40);
      check("clk or", 32'(clk_o), 32'h1);
      raise(48'h1 << 20 | 48'h1 << 21 | 48'h8);
      check("sys or", 32'(sys_o), 32'h1);
      rdchk("no service", `EIA_IDX_ISV_HI, 32'h0);
      check("ext kept", 32'(pend[3]), 32'h1);
      sw_clr_r <= 48'h1 << 20;
      @(posedge clk);
      sw_clr_r <= 48'h0;
      repeat (3) @(posedge clk);
      check("sys held", 32'(sys_o), 32'h1);
      sw_clr_r <= 48'hFFFF_FFFF_FFFF;
      @(posedge clk);
      sw_clr_r <= 48'h0;
      repeat (3) @(posedge clk);
      check("sys idle", 32'(sys_o), 32'h0);
      check("clk idle", 32'(clk_o), 32'h0);
      $display("test disabled done");
   endtask
   task automatic t_flat();
      int ks[8] = '{0, 7, 8, 15, 16, 31, 32, 47};
      wr(`EIA_IDX_MODE, `EIA_MODE_FLAT);
      wr(`EIA_IDX_ROUTE, `EIA_ROUTE_ON);
      foreach (ks[i]) begin
         raise(48'h1 << ks[i]);
         check("level", 32'(sys_o), 32'h1);
         check("pci oe", {31'h0, pci_oe} | {pci_o, 31'h0}, 32'h1);
         nxt(ks[i]);
      end
      wr(`EIA_IDX_ROUTE, 8'h00);
      raise(48'h1 << 20);
      check("pci off", 32'(pci_oe), 32'h0);
      nxt(20);
      raise(48'h1 << 10 | 48'h1 << 30);
      nxt(30);
      nxt(10);
      $display("test flat done");
   endtask
   task automatic t_tier();
      wr(`EIA_IDX_MODE, `EIA_MODE_TIER);
      raise(48'h1 | 48'h1 << 19 | 48'h1 << 36);
      nxt(36);
      nxt(19);
      nxt(0);
      raise(48'h1 << 20);
      nxt(20);
      raise(48'h1 << 18 | 48'h1 << 22);
      nxt(22);
      nxt(18);
      wr(`EIA_IDX_MODE, `EIA_MODE_PRE);
      raise(48'h2);
      raise(48'h1 << 33);
      nxt(33);
      $display("test tier done");
   endtask
   task automatic t_fmt();
      int hs, hc;
      wr(`EIA_IDX_MODE, `EIA_MODE_FLAT);
      wr(`EIA_IDX_CLK_FMT, 8'h01);
      raise(48'h1 << 34);
      check("clk low lvl", 32'(clk_o), 32'h0);
      nxt(34);
      check("clk low idle", 32'(clk_o), 32'h1);
      wr(`EIA_IDX_SYS_FMT, 8'h10);
      wr(`EIA_IDX_SYS_PW, 8'h01);
      wr(`EIA_IDX_CLK_FMT, 8'h10);
      wr(`EIA_IDX_CLK_PW, 8'h00);
      set_r <= 48'h1 << 35;
      @(posedge clk);
      set_r <= 48'h0;
      measure(1'b1, hs, hc);
      check("sys pulse", 32'(hs >= 14 && hs <= 16), 32'h1);
      check("clk pulse", 32'(hc >= 7 && hc <= 8), 32'h1);
      nxt(35);
      wr(`EIA_IDX_CLK_FMT, 8'h11);
      wr(`EIA_IDX_SYS_FMT, 8'h11);
      measure(1'b0, hs, hc);
      check("low idle", 32'(hs + hc), 32'h0);
      $display("test format done");
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_off();
      t_flat();
      t_tier();
      t_fmt();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
